/* verilog/tmr_ccp_pkg.sv */
// Package: register map, field positions and reset values of the capture/compare timer
package tmr_ccp_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE_CTL = 8'h00; // mode_control_reg
  localparam logic [7:0] ADDR_CC_CTL = 8'h04; // capcomp_control_reg
  localparam logic [7:0] ADDR_PRESCALE = 8'h08; // prescaler_edge_reg
  localparam logic [7:0] ADDR_OUT_CTL = 8'h0C; // output_control_reg
  localparam logic [7:0] ADDR_COUNT = 8'h10; // timer_count_reg, read only
  localparam logic [7:0] ADDR_CC_A = 8'h14; // capcomp_reg_a
  localparam logic [7:0] ADDR_CC_B = 8'h18; // capcomp_reg_b
  localparam logic [7:0] ADDR_IRQ_STS = 8'h1C; // sticky status, write one to clear
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h20; // interrupt enable mask

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_HI = 3; // op_mode_bit_hi
  localparam int MODE_LO = 2; // op_mode_bit_lo
  localparam int TOG_SEL_BIT = 1; // output_toggle_select
  localparam int OVF_BIT = 0; // overflow_flag
  localparam int CC_A_CAPT_BIT = 0; // register A captures when set
  localparam int CC_A_TRIG_BIT = 1; // register A trigger: 1 input A, 0 input B
  localparam int CC_B_CAPT_BIT = 2; // register B captures when set
  localparam int CLK_SEL_HI = 1; // count clock divide select
  localparam int ES_A_LO = 4; // edge select of trigger_input_a
  localparam int ES_B_LO = 6; // edge select of trigger_input_b
  localparam int OUT_EN_BIT = 0; // timer output enable
  localparam int STS_A_BIT = 0; // event on register A
  localparam int STS_B_BIT = 1; // event on register B
  localparam int STS_OVF_BIT = 2; // counter overflow

  // ----------------------------------------------------------------
  // Operating modes and edge selections
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_STOP = 2'h0;
  localparam logic [1:0] MODE_FREE = 2'h1;
  localparam logic [1:0] MODE_CLR_TRIG = 2'h2;
  localparam logic [1:0] MODE_PPG = 2'h3;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_NONE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [3:0] RST_MODE_CTL = 4'h0;
  localparam logic [2:0] RST_CC_CTL = 3'h0;
  localparam logic [7:0] RST_PRESCALE = 8'h00;
  localparam logic [15:0] RST_CC = 16'h0000;
  localparam logic [2:0] RST_IRQ_MSK = 3'h0;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;

endpackage : tmr_ccp_pkg

/* verilog/tmr_ccp.sv */
// Top module: 16-bit capture/compare timer with pulse generation and APB registers
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module tmr_ccp
  import tmr_ccp_pkg::*;
(
  input wire logic ref_clk, // 100 MHz clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic clk_en, // Freezes all state while low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic trigger_input_a, // External trigger A
  input wire logic trigger_input_b, // External trigger B
  output logic timer_output_pin, // Timer output
  output logic match_irq_a, // Register A event pulse
  output logic match_irq_b, // Register B event pulse
  output logic irq // Level interrupt
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] mode_ctl;
    logic [2:0] cc_ctl;
    logic [7:0] prescale;
    logic out_en;
    logic [15:0] count;
    logic [15:0] cc_a;
    logic [15:0] cc_b;
    logic [2:0] sts;
    logic [2:0] msk;
    logic [2:0] div;
    logic trg_a_prev;
    logic trg_b_prev;
    logic tout;
    logic evt_a;
    logic evt_b;
    logic [31:0] rdata;
    logic slverr;
  } state_t;

  state_t cur_ff;
  state_t nxt_st;
  logic [1:0] rst_sync_ff;
  logic rst_n;

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  logic [1:0] mode;
  logic running;
  logic a_capt;
  logic b_capt;
  logic a_on_input_a;
  logic tick;
  logic [2:0] div_mask;
  logic edge_a;
  logic edge_b;
  logic trig_for_a;
  logic match_a;
  logic match_b;
  logic b_edges_used;
  logic wr_acc;
  logic [7:0] wr_ovf_mode;

  // Edge qualifier by select code
  function automatic logic edge_ok(input logic [1:0] sel, input logic prev, input logic now);
    logic rise;
    logic fall;
    rise = !prev && now;
    fall = prev && !now;
    case (sel)
      EDGE_FALL: edge_ok = fall;
      EDGE_RISE: edge_ok = rise;
      EDGE_BOTH: edge_ok = rise || fall;
      default: edge_ok = 1'b0;
    endcase
  endfunction : edge_ok

  // Mode fields and count clock tick
  assign mode = cur_ff.mode_ctl[MODE_HI:MODE_LO];
  assign running = (mode != MODE_STOP);
  assign a_capt = cur_ff.cc_ctl[CC_A_CAPT_BIT];
  assign b_capt = cur_ff.cc_ctl[CC_B_CAPT_BIT];
  assign a_on_input_a = cur_ff.cc_ctl[CC_A_TRIG_BIT];
  assign div_mask = 3'((4'h1 << cur_ff.prescale[CLK_SEL_HI:0]) - 4'h1);
  assign tick = clk_en && running && ((cur_ff.div & div_mask) == div_mask);

  // Trigger edges and compare matches
  assign edge_a = clk_en && running &&
    edge_ok(cur_ff.prescale[ES_A_LO+1:ES_A_LO], cur_ff.trg_a_prev, trigger_input_a);
  assign edge_b = clk_en && running &&
    edge_ok(cur_ff.prescale[ES_B_LO+1:ES_B_LO], cur_ff.trg_b_prev, trigger_input_b);
  assign trig_for_a = a_on_input_a ? edge_a : edge_b;
  assign match_a = tick && !a_capt && (cur_ff.count == cur_ff.cc_a);
  assign match_b = tick && !b_capt && (cur_ff.count == cur_ff.cc_b);
  assign b_edges_used = a_capt && !a_on_input_a;

  // Bus strobes
  assign wr_acc = clk_en && psel && penable && pwrite;
  assign wr_ovf_mode = pwdata[7:0];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = cur_ff;
    if (clk_en) begin
      nxt_st.evt_a = 1'b0;
      nxt_st.evt_b = 1'b0;
      nxt_st.trg_a_prev = trigger_input_a;
      nxt_st.trg_b_prev = trigger_input_b;
      nxt_st.div = running ? 3'(cur_ff.div + 3'h1) : 3'h0;

      // Register writes
      if (wr_acc) begin
        if (paddr == ADDR_MODE_CTL) begin
          nxt_st.mode_ctl = wr_ovf_mode[3:0];
          nxt_st.mode_ctl[OVF_BIT] = cur_ff.mode_ctl[OVF_BIT] & wr_ovf_mode[OVF_BIT];
        end else if (paddr == ADDR_CC_CTL) begin
          nxt_st.cc_ctl = pwdata[2:0];
        end else if (paddr == ADDR_PRESCALE) begin
          nxt_st.prescale = pwdata[7:0];
        end else if (paddr == ADDR_OUT_CTL) begin
          nxt_st.out_en = pwdata[OUT_EN_BIT];
        end else if (paddr == ADDR_CC_A) begin
          nxt_st.cc_a = pwdata[15:0];
        end else if (paddr == ADDR_CC_B) begin
          nxt_st.cc_b = pwdata[15:0];
        end else if (paddr == ADDR_IRQ_STS) begin
          nxt_st.sts = cur_ff.sts & ~pwdata[2:0];
        end else if (paddr == ADDR_IRQ_MSK) begin
          nxt_st.msk = pwdata[2:0];
        end
      end

      // Counter: stop, free run, clear on match A
      if (!running) begin
        nxt_st.count = COUNT_ZERO;
        nxt_st.tout = 1'b0;
      end else if (tick) begin
        if (mode == MODE_PPG && cur_ff.count == cur_ff.cc_a) begin
          nxt_st.count = COUNT_ZERO;
        end else begin
          nxt_st.count = 16'(cur_ff.count + 16'h0001);
        end
        if (mode != MODE_PPG && cur_ff.count == COUNT_MAX) begin
          nxt_st.mode_ctl[OVF_BIT] = 1'b1;
          nxt_st.sts[STS_OVF_BIT] = 1'b1;
        end
      end

      // Timer output
      if (running && mode == MODE_PPG) begin
        if (tick && cur_ff.count == cur_ff.cc_a) begin
          nxt_st.tout = 1'b1;
        end else if (tick && cur_ff.count == cur_ff.cc_b) begin
          nxt_st.tout = 1'b0;
        end
      end else if (running) begin
        if (match_a || match_b) begin
          nxt_st.tout = !cur_ff.tout;
        end else if (a_capt && b_capt && cur_ff.mode_ctl[TOG_SEL_BIT] && edge_a) begin
          nxt_st.tout = !cur_ff.tout;
        end
      end

      // Register A events
      if (a_capt && trig_for_a && mode != MODE_PPG) begin
        nxt_st.cc_a = cur_ff.count;
        nxt_st.evt_a = 1'b1;
      end else if (match_a) begin
        nxt_st.evt_a = 1'b1;
      end

      // Register B events
      if (b_capt && edge_a && mode != MODE_PPG) begin
        nxt_st.cc_b = cur_ff.count;
        nxt_st.evt_b = 1'b1;
      end else if (match_b) begin
        nxt_st.evt_b = 1'b1;
      end

      // Sticky status, set wins over clear
      if (nxt_st.evt_a) begin
        nxt_st.sts[STS_A_BIT] = 1'b1;
      end
      if (nxt_st.evt_b) begin
        nxt_st.sts[STS_B_BIT] = 1'b1;
      end

      // Read data and error, prepared every selected cycle
      nxt_st.slverr = 1'b0;
      nxt_st.rdata = 32'h0000_0000;
      if (psel) begin
        if (paddr == ADDR_MODE_CTL) begin
          nxt_st.rdata[3:0] = cur_ff.mode_ctl;
        end else if (paddr == ADDR_CC_CTL) begin
          nxt_st.rdata[2:0] = cur_ff.cc_ctl;
        end else if (paddr == ADDR_PRESCALE) begin
          nxt_st.rdata[7:0] = cur_ff.prescale;
        end else if (paddr == ADDR_OUT_CTL) begin
          nxt_st.rdata[OUT_EN_BIT] = cur_ff.out_en;
        end else if (paddr == ADDR_COUNT) begin
          nxt_st.rdata[15:0] = cur_ff.count;
        end else if (paddr == ADDR_CC_A) begin
          nxt_st.rdata[15:0] = cur_ff.cc_a;
        end else if (paddr == ADDR_CC_B) begin
          nxt_st.rdata[15:0] = cur_ff.cc_b;
        end else if (paddr == ADDR_IRQ_STS) begin
          nxt_st.rdata[2:0] = cur_ff.sts;
        end else if (paddr == ADDR_IRQ_MSK) begin
          nxt_st.rdata[2:0] = cur_ff.msk;
        end else begin
          nxt_st.slverr = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
      cur_ff.mode_ctl <= RST_MODE_CTL;
      cur_ff.cc_ctl <= RST_CC_CTL;
      cur_ff.prescale <= RST_PRESCALE;
      cur_ff.cc_a <= RST_CC;
      cur_ff.cc_b <= RST_CC;
      cur_ff.msk <= RST_IRQ_MSK;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // Outputs
  assign pready = clk_en;
  assign prdata = cur_ff.rdata;
  assign pslverr = cur_ff.slverr && psel && penable;
  assign timer_output_pin = cur_ff.tout && cur_ff.out_en && !b_edges_used;
  assign match_irq_a = cur_ff.evt_a;
  assign match_irq_b = cur_ff.evt_b;
  assign irq = |(cur_ff.sts & cur_ff.msk);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic free_mode;
  assign free_mode = (mode == MODE_FREE);

  sequence s_wrap;
    tick && free_mode && cur_ff.count == COUNT_MAX;
  endsequence

  property p_wrap;
    @(posedge ref_clk) disable iff (!rst_n)
    s_wrap |=> cur_ff.count == COUNT_ZERO && cur_ff.mode_ctl[OVF_BIT] && cur_ff.sts[STS_OVF_BIT];
  endproperty
  a_wrap: assert property (p_wrap) else $error("overflow wrap failed");

  property p_count_up;
    @(posedge ref_clk) disable iff (!rst_n)
    tick && free_mode && cur_ff.count != COUNT_MAX |=>
      cur_ff.count == 16'($past(cur_ff.count) + 16'h0001);
  endproperty
  a_count_up: assert property (p_count_up) else $error("count did not advance");

  property p_cmp_a;
    @(posedge ref_clk) disable iff (!rst_n)
    match_a && mode != MODE_PPG && cur_ff.count != COUNT_MAX |=>
      match_irq_a && cur_ff.count != COUNT_ZERO;
  endproperty
  a_cmp_a: assert property (p_cmp_a) else $error("compare A event missing");

  property p_cmp_b;
    @(posedge ref_clk) disable iff (!rst_n)
    match_b |=> match_irq_b ##1 !match_irq_b || $past(match_b);
  endproperty
  a_cmp_b: assert property (p_cmp_b) else $error("compare B event missing");

  property p_cap_b;
    @(posedge ref_clk) disable iff (!rst_n)
    b_capt && edge_a && mode != MODE_PPG |=>
      cur_ff.cc_b == $past(cur_ff.count) && match_irq_b && cur_ff.sts[STS_B_BIT];
  endproperty
  a_cap_b: assert property (p_cap_b) else $error("capture B failed");

  property p_stop;
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && !running |=> cur_ff.count == COUNT_ZERO && !match_irq_a && !match_irq_b;
  endproperty
  a_stop: assert property (p_stop) else $error("stopped timer active");

  property p_ppg_clear;
    @(posedge ref_clk) disable iff (!rst_n)
    tick && mode == MODE_PPG && cur_ff.count == cur_ff.cc_a |=>
      cur_ff.count == COUNT_ZERO && cur_ff.tout;
  endproperty
  a_ppg_clear: assert property (p_ppg_clear) else $error("pulse period restart failed");

  property p_no_toggle;
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && free_mode && a_capt && b_capt && !cur_ff.mode_ctl[TOG_SEL_BIT] |=>
      $stable(cur_ff.tout);
  endproperty
  a_no_toggle: assert property (p_no_toggle) else $error("output toggled in capture mode");

  property p_both_edges;
    @(posedge ref_clk) disable iff (!rst_n)
    clk_en && running && cur_ff.prescale[ES_A_LO+1:ES_A_LO] == EDGE_BOTH &&
      trigger_input_a != cur_ff.trg_a_prev |-> edge_a;
  endproperty
  a_both_edges: assert property (p_both_edges) else $error("edge not detected");

  property p_out_gate;
    @(posedge ref_clk) disable iff (!rst_n)
    b_edges_used |-> !timer_output_pin;
  endproperty
  a_out_gate: assert property (p_out_gate) else $error("output active with input B edges");

endmodule : tmr_ccp

`default_nettype wire

/* testbench/trig_partner.sv */
// Partner model: drives both trigger inputs and measures the timer output
`timescale 1ns/1ns
`default_nettype none

module trig_partner (
  input wire logic ref_clk, // Bench clock
  input wire logic timer_output_pin, // Timer output under watch
  output logic trigger_input_a, // Trigger level A
  output logic trigger_input_b, // Trigger level B
  output int n_toggles, // Output level changes seen
  output int hi_len, // Last high width in cycles
  output int per_len // Last rise-to-rise period in cycles
);
  int run_hi = 0;
  int run_per = 0;
  logic last_out = 1'b0;

  // Triggers idle low
  initial begin
    trigger_input_a = 1'b0;
    trigger_input_b = 1'b0;
  end

  // Change one trigger level after an edge, then hold it long enough to be seen
  task automatic drive(input logic sel_b, input logic lvl);
    @(posedge ref_clk);
    if (sel_b) begin
      trigger_input_b <= lvl;
    end else begin
      trigger_input_a <= lvl;
    end
    repeat (8) @(posedge ref_clk);
  endtask : drive

  // Width and period of the output; read only while input B edges are unused
  always @(posedge ref_clk) begin
    run_per <= run_per + 1;
    if (timer_output_pin === 1'b1) run_hi <= run_hi + 1;
    if (timer_output_pin !== last_out) n_toggles <= n_toggles + 1;
    if (timer_output_pin === 1'b1 && last_out === 1'b0) begin
      per_len <= run_per;
      run_per <= 1;
      run_hi <= 1;
    end
    if (timer_output_pin === 1'b0 && last_out === 1'b1) hi_len <= run_hi;
    last_out <= timer_output_pin;
  end

endmodule : trig_partner

`default_nettype wire

/* testbench/tb_tmr_ccp.sv */
// Testbench: register-driven checks of the capture/compare timer
`timescale 1ns/1ns
`default_nettype none

module tb_tmr_ccp
  import tmr_ccp_pkg::*;
;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, trigger_input_a, trigger_input_b;
  logic timer_output_pin, match_irq_a, match_irq_b, irq, slv;
  logic [31:0] q, c1, v;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int na = 0;
  int nb = 0;
  int a0, b0, t0, t, ntog, hi_len, per_len;
  int rise_exp [4] = '{0, 1, 0, 1};
  int tot_exp [4] = '{1, 1, 0, 2};

  tmr_ccp i_tmr_ccp (
    .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigger_input_a(trigger_input_a), .trigger_input_b(trigger_input_b),
    .timer_output_pin(timer_output_pin), .match_irq_a(match_irq_a),
    .match_irq_b(match_irq_b), .irq(irq)
  );

  trig_partner i_trig_partner (
    .ref_clk(ref_clk), .timer_output_pin(timer_output_pin), .trigger_input_a(trigger_input_a),
    .trigger_input_b(trigger_input_b), .n_toggles(ntog), .hi_len(hi_len), .per_len(per_len)
  );

  // 100 MHz clock
  initial forever #5 ref_clk = ~ref_clk;

  // Event pulse counters and run watchdog
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (match_irq_a === 1'b1) na <= na + 1;
    if (match_irq_b === 1'b1) nb <= nb + 1;
    if (cyc == 80000) begin
      err_count++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One transfer: setup, access until ready, data taken at the edge that sees ready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int w;
    w = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && w < 50) begin
      @(posedge ref_clk);
      w++;
    end
    if (w == 50) err_count++;
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic chk_irq(input logic [31:0] exp);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(irq, exp);
  endtask : chk_irq

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    // Reset state, read-only count, unmapped place
    rd(ADDR_MODE_CTL);
    chk(q, 32'h0);
    wr(ADDR_COUNT, 32'h1234);
    rd(ADDR_COUNT);
    chk(q, 32'h0);
    rd(8'h30);
    chk({q[30:0], slv}, 32'h1);
    // Two compares in free run, masked interrupt
    wr(ADDR_CC_A, 32'h40);
    wr(ADDR_CC_B, 32'h80);
    wr(ADDR_OUT_CTL, 32'h1);
    wr(ADDR_IRQ_MSK, 32'h1);
    t0 = ntog;
    wr(ADDR_MODE_CTL, 32'h4);
    repeat (200) @(posedge ref_clk);
    chk(na, 32'h1);
    chk(nb, 32'h1);
    chk(ntog - t0, 32'h2);
    rd(ADDR_COUNT);
    c1 = q;
    rd(ADDR_COUNT);
    chk(32'(c1 > 32'h80), 32'h1);
    chk(q - c1, 32'h3);
    // Clock enable low freezes the count
    c1 = q;
    clk_en <= 1'b0;
    repeat (20) @(posedge ref_clk);
    clk_en <= 1'b1;
    rd(ADDR_COUNT);
    chk(q - c1, 32'h3);
    rd(ADDR_IRQ_STS);
    chk(q, 32'h3);
    chk_irq(32'h1);
    wr(ADDR_IRQ_STS, 32'h1);
    chk_irq(32'h0);
    wr(ADDR_IRQ_MSK, 32'h0);
    wr(ADDR_IRQ_STS, 32'h2);
    // Stopped: count held at zero, no match on a zero compare
    wr(ADDR_MODE_CTL, 32'h0);
    rd(ADDR_COUNT);
    chk(q, 32'h0);
    a0 = na;
    wr(ADDR_CC_A, 32'h0);
    repeat (30) @(posedge ref_clk);
    chk(na - a0, 32'h0);
    // Capture into B on input A for each edge selection
    wr(ADDR_CC_A, 32'hFFF0);
    wr(ADDR_CC_CTL, 32'h4);
    wr(ADDR_MODE_CTL, 32'h4);
    for (int es = 0; es < 4; es++) begin
      wr(ADDR_PRESCALE, 32'(es << ES_A_LO));
      b0 = nb;
      rd(ADDR_COUNT);
      c1 = q;
      i_trig_partner.drive(1'b0, 1'b1);
      rd(ADDR_CC_B);
      v = q;
      rd(ADDR_COUNT);
      chk(nb - b0, rise_exp[es]);
      if (rise_exp[es] == 1) chk(32'(v > c1 && v < q), 32'h1);
      i_trig_partner.drive(1'b0, 1'b0);
      chk(nb - b0, tot_exp[es]);
    end
    // Both capture on input A: toggle only with the select bit
    wr(ADDR_CC_CTL, 32'h7);
    wr(ADDR_PRESCALE, 32'h90);
    t0 = ntog;
    i_trig_partner.drive(1'b0, 1'b1);
    i_trig_partner.drive(1'b0, 1'b0);
    chk(ntog - t0, 32'h0);
    wr(ADDR_MODE_CTL, 32'h6);
    t0 = ntog;
    i_trig_partner.drive(1'b0, 1'b1);
    i_trig_partner.drive(1'b0, 1'b0);
    chk(ntog - t0, 32'h1);
    rd(ADDR_CC_A);
    v = q;
    rd(ADDR_CC_B);
    chk(q, v);
    // Register A on input B; input B alone never reaches register B
    wr(ADDR_CC_CTL, 32'h5);
    wr(ADDR_PRESCALE, 32'h60);
    wr(ADDR_MODE_CTL, 32'h4);
    rd(ADDR_CC_B);
    v = q;
    a0 = na;
    b0 = nb;
    rd(ADDR_COUNT);
    c1 = q;
    i_trig_partner.drive(1'b1, 1'b1);
    chk(timer_output_pin, 32'h0);
    rd(ADDR_CC_A);
    chk(32'(q > c1), 32'h1);
    chk(na - a0, 32'h1);
    chk(nb - b0, 32'h0);
    rd(ADDR_CC_B);
    chk(q, v);
    i_trig_partner.drive(1'b1, 1'b0);
    // Pulse generation: period 10, high 4
    wr(ADDR_MODE_CTL, 32'h0);
    wr(ADDR_CC_CTL, 32'h0);
    wr(ADDR_PRESCALE, 32'h0);
    wr(ADDR_CC_A, 32'h9);
    wr(ADDR_CC_B, 32'h3);
    wr(ADDR_MODE_CTL, 32'hC);
    repeat (60) @(posedge ref_clk);
    chk(per_len, 32'hA);
    chk(hi_len, 32'h4);
    rd(ADDR_COUNT);
    chk(32'(q < 32'hA), 32'h1);
    // Wrap from the top count and software clear of the flag
    wr(ADDR_MODE_CTL, 32'h0);
    wr(ADDR_IRQ_STS, 32'h7);
    wr(ADDR_IRQ_MSK, 32'h4);
    wr(ADDR_MODE_CTL, 32'h4);
    t = 0;
    while (irq !== 1'b1 && t < 70000) begin
      @(posedge ref_clk);
      t++;
    end
    rd(ADDR_COUNT);
    chk(32'(q < 32'h100), 32'h1);
    rd(ADDR_MODE_CTL);
    chk(q, 32'h5);
    wr(ADDR_MODE_CTL, 32'h4);
    rd(ADDR_MODE_CTL);
    chk(q, 32'h4);
    wr(ADDR_IRQ_STS, 32'h4);
    chk_irq(32'h0);
    finish_test();
  end

endmodule : tb_tmr_ccp

`default_nettype wire
